// ### hw/volume_ramp_regs.svh
// Purpose: register offsets, field positions, reset values and limits of the volume stage
// Assumes: 8-bit register port, 8-bit volume codes in half-dB units
// Notes:   definitions only
`ifndef VOLUME_RAMP_REGS_SVH
`define VOLUME_RAMP_REGS_SVH

// ==========================================================
// offsets
`define OFS_CLOCK_DETECT_STATUS   8'h39
`define OFS_VOLUME_LEVEL          8'h4C
`define OFS_VOLUME_RAMP_CONTROL   8'h4E
`define OFS_EMERGENCY_RAMP_CTRL   8'h4F

// ==========================================================
// reset values
`define RST_VOLUME_LEVEL          8'h30
`define RST_VOLUME_RAMP_CONTROL   8'h33
`define RST_EMERGENCY_RAMP_CTRL   8'h30
`define RST_STATUS_RESERVED       2'h0
`define RST_READ_DATA             8'h00

// ==========================================================
// field positions (low bit of each 2-bit field, single-bit status flags by bit number)
`define FLD_FALL_RATE             6
`define FLD_FALL_STEP             4
`define FLD_RISE_RATE             2
`define FLD_RISE_STEP             0
`define FLD_STATUS_RESERVED       6
`define BIT_BCLK_RATE_ERR         5
`define BIT_PLL_OVERRATE          4
`define BIT_PLL_LOCKED            3
`define BIT_BCLK_MISSING          2
`define BIT_BCLK_VALID            1
`define BIT_FS_ERROR              0

// ==========================================================
// codes and limits
`define RATE_INSTANT              2'h3
`define VOLUME_MUTE               8'hFF
`define VOLUME_STEPS_PER_6DB      8'h0C
`define BCLK_RATIO_MIN            10'h020
`define BCLK_RATIO_MAX            10'h200
`define GAIN_SHIFT_BASE           6'h0B

`endif

// ### hw/volume_ramp_pkg.sv
// Purpose: shared types of the volume ramp stage
// Assumes: 24-bit signed samples, two channels
// Notes:   constants live in volume_ramp_regs.svh
package volume_ramp_pkg;

    typedef struct packed {
        logic signed [23:0] left;
        logic signed [23:0] right;
    } stereo_sample_t;

    typedef struct packed {
        logic       bclk_rate_bad;
        logic       pll_overrate;
        logic       pll_locked;
        logic       pll_enabled;
        logic       bclk_missing;
        logic       ratio_stable;
        logic [9:0] bclk_ratio;
        logic       fs_auto_mode;
        logic       detected_fs_valid;
        logic [3:0] detected_fs;
        logic [3:0] configured_fs;
        logic       fs_error_ignore;
        logic       emergency_mute;
    } health_in_t;

    typedef enum logic [1:0] {
        RAMP_IDLE  = 2'b00,
        RAMP_FALL  = 2'b01,
        RAMP_RISE  = 2'b11,
        RAMP_EMERG = 2'b10
    } ramp_state_t;

endpackage

// ### hw/gain_apply.sv
// Purpose: multiplies both channels of a frame by the gain of one volume code
// Assumes: code in half-dB steps, 0x00 is +24 dB, 0xFF mutes
// Notes:   one cycle latency, saturating; 6 dB taken as one binary shift
`timescale 1ns/100ps
`include "volume_ramp_regs.svh"

module gain_apply (
    input  wire logic                            ref_clk,
    input  wire logic                            rst,
    input  wire logic [7:0]                      volume_code,
    input  wire volume_ramp_pkg::stereo_sample_t in_sample,
    input  wire logic                            in_valid,
    output volume_ramp_pkg::stereo_sample_t      out_sample,
    output logic                                 out_valid
);

    // ==========================================================
    // half-dB fractions of one 6 dB octave, Q1.15
    function automatic logic [15:0] mantissa(input logic [7:0] r);
        case (r)
            8'h00:   mantissa = 16'h8000;
            8'h01:   mantissa = 16'h78D7;
            8'h02:   mantissa = 16'h7215;
            8'h03:   mantissa = 16'h6BB3;
            8'h04:   mantissa = 16'h65AD;
            8'h05:   mantissa = 16'h5FFD;
            8'h06:   mantissa = 16'h5A9E;
            8'h07:   mantissa = 16'h558C;
            8'h08:   mantissa = 16'h50C3;
            8'h09:   mantissa = 16'h4C3F;
            8'h0A:   mantissa = 16'h47FB;
            default: mantissa = 16'h43F4;
        endcase
    endfunction

    function automatic logic signed [23:0] scale(input logic signed [23:0] s,
                                                 input logic [7:0] code);
        logic        [7:0]  octave;
        logic signed [40:0] prod;
        logic signed [40:0] shifted;
        octave  = code / `VOLUME_STEPS_PER_6DB;
        prod    = s * $signed({1'b0, mantissa(code % `VOLUME_STEPS_PER_6DB)});
        shifted = prod >>> (`GAIN_SHIFT_BASE + octave[5:0]);
        if (code == `VOLUME_MUTE) begin
            scale = 24'sh000000;
        end else if (shifted > 41'sh00007FFFFF) begin
            scale = 24'sh7FFFFF;
        end else if (shifted < -41'sh0000800000) begin
            scale = 24'sh800000;
        end else begin
            scale = shifted[23:0];
        end
    endfunction

    // ==========================================================
    // output stage
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_sample <= '0;
            out_valid  <= 1'b0;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_sample.left  <= scale(in_sample.left, volume_code);
                out_sample.right <= scale(in_sample.right, volume_code);
            end
        end
    end

endmodule

// ### hw/volume_ramp.sv
// Purpose: stereo digital volume with stepped ramps and clock health status
// Assumes: fs_tick is a one-cycle frame strobe from logic on ref_clk
// Notes:   health inputs come from other domains and are synchronised here
//
// Notes on behaviour
// - status bit 5 flags bit clock rate error
// - status bit 4 flags PLL overrate
// - status bit 3 lock, unlocked while PLL disabled
// - status bit 2 flags missing bit clock
// - bit 1 valid when ratio stable, 32-512
// - bit 0 rate valid or rate mismatch
// - ignore setting never masks rate error
// - one code both channels, 0.5 dB steps
// - falling updates every 1/2/4 frames, or instant
// - falling step 4/2/1/0.5 dB per update
// - rising updates every 1/2/4 frames, or instant
// - rising step 4/2/1/0.5 dB per update
// - emergency fall uses its own rate, step
`timescale 1ns/100ps
`include "volume_ramp_regs.svh"

module volume_ramp (
    input  wire logic                            ref_clk,
    input  wire logic                            rst,
    input  wire logic [7:0]                      reg_addr,
    input  wire logic [7:0]                      reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic [7:0]                           reg_rdata,
    input  wire volume_ramp_pkg::health_in_t     health_in,
    input  wire logic                            fs_tick,
    input  wire volume_ramp_pkg::stereo_sample_t in_sample,
    input  wire logic                            in_valid,
    output volume_ramp_pkg::stereo_sample_t      out_sample,
    output logic                                 out_valid
);

    logic [7:0]                    volume_level;
    logic [7:0]                    volume_ramp_control;
    logic [7:0]                    emergency_ramp_control;
    logic [1:0]                    status_reserved;
    logic [5:0]                    clock_health_flags;
    volume_ramp_pkg::health_in_t   health_meta;
    volume_ramp_pkg::health_in_t   health;
    volume_ramp_pkg::ramp_state_t  ramp_state;
    volume_ramp_pkg::ramp_state_t  next_ramp_state;
    logic [7:0]                    volume_code;
    logic [7:0]                    target;
    logic [7:0]                    next_volume_code;
    logic [1:0]                    frame_count;
    logic [1:0]                    rate_sel;
    logic [1:0]                    step_sel;
    logic                          update_now;

    // ==========================================================
    // update period minus one, in frames
    function automatic logic [1:0] rate_last(input logic [1:0] rate);
        case (rate)
            2'h0:    rate_last = 2'h0;
            2'h1:    rate_last = 2'h1;
            default: rate_last = 2'h3;
        endcase
    endfunction

    // step size in half-dB codes
    function automatic logic [7:0] step_codes(input logic [1:0] step);
        case (step)
            2'h0:    step_codes = 8'h08;
            2'h1:    step_codes = 8'h04;
            2'h2:    step_codes = 8'h02;
            default: step_codes = 8'h01;
        endcase
    endfunction

    // ==========================================================
    // register writes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            volume_level           <= `RST_VOLUME_LEVEL;
            volume_ramp_control    <= `RST_VOLUME_RAMP_CONTROL;
            emergency_ramp_control <= `RST_EMERGENCY_RAMP_CTRL;
            status_reserved        <= `RST_STATUS_RESERVED;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFS_VOLUME_LEVEL:        volume_level <= reg_wdata;
                `OFS_VOLUME_RAMP_CONTROL: volume_ramp_control <= reg_wdata;
                `OFS_EMERGENCY_RAMP_CTRL: emergency_ramp_control <= reg_wdata;
                `OFS_CLOCK_DETECT_STATUS: begin
                    status_reserved <= reg_wdata[`FLD_STATUS_RESERVED +: 2];
                end
                default: ;
            endcase
        end
    end

    // register reads, unmapped read as zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= `RST_READ_DATA;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFS_VOLUME_LEVEL:        reg_rdata <= volume_level;
                `OFS_VOLUME_RAMP_CONTROL: reg_rdata <= volume_ramp_control;
                `OFS_EMERGENCY_RAMP_CTRL: reg_rdata <= emergency_ramp_control;
                `OFS_CLOCK_DETECT_STATUS: reg_rdata <= {status_reserved, clock_health_flags};
                default:                  reg_rdata <= `RST_READ_DATA;
            endcase
        end
    end

    // ==========================================================
    // two-stage synchroniser for detector levels
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            health_meta <= '0;
            health      <= '0;
        end else begin
            health_meta <= health_in;
            health      <= health_meta;
        end
    end

    // ==========================================================
    // clock health flags
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clock_health_flags <= '0;
        end else begin
            clock_health_flags[`BIT_BCLK_RATE_ERR] <= health.bclk_rate_bad;
            clock_health_flags[`BIT_PLL_OVERRATE]  <= health.pll_overrate;
            clock_health_flags[`BIT_PLL_LOCKED]    <= health.pll_locked & health.pll_enabled;
            clock_health_flags[`BIT_BCLK_MISSING]  <= health.bclk_missing;
            clock_health_flags[`BIT_BCLK_VALID]    <= health.ratio_stable
                && health.bclk_ratio >= `BCLK_RATIO_MIN
                && health.bclk_ratio <= `BCLK_RATIO_MAX;
            clock_health_flags[`BIT_FS_ERROR]      <= health.fs_auto_mode
                ? health.detected_fs_valid
                : (health.detected_fs != health.configured_fs);
        end
    end

    // ==========================================================
    // ramp direction and setting choice
    // emergency forces mute target
    assign target = health.emergency_mute ? `VOLUME_MUTE : volume_level;

    always_comb begin
        if (volume_code == target) begin
            next_ramp_state = volume_ramp_pkg::RAMP_IDLE;
        end else if (volume_code < target) begin
            next_ramp_state = health.emergency_mute ? volume_ramp_pkg::RAMP_EMERG
                                                    : volume_ramp_pkg::RAMP_FALL;
        end else begin
            next_ramp_state = volume_ramp_pkg::RAMP_RISE;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ramp_state <= volume_ramp_pkg::RAMP_IDLE;
        end else begin
            ramp_state <= next_ramp_state;
        end
    end

    always_comb begin
        case (next_ramp_state)
            volume_ramp_pkg::RAMP_EMERG: begin
                rate_sel = emergency_ramp_control[`FLD_FALL_RATE +: 2];
                step_sel = emergency_ramp_control[`FLD_FALL_STEP +: 2];
            end
            volume_ramp_pkg::RAMP_RISE: begin
                rate_sel = volume_ramp_control[`FLD_RISE_RATE +: 2];
                step_sel = volume_ramp_control[`FLD_RISE_STEP +: 2];
            end
            default: begin
                rate_sel = volume_ramp_control[`FLD_FALL_RATE +: 2];
                step_sel = volume_ramp_control[`FLD_FALL_STEP +: 2];
            end
        endcase
    end

    assign update_now = fs_tick && next_ramp_state != volume_ramp_pkg::RAMP_IDLE
        && (rate_sel == `RATE_INSTANT || frame_count == rate_last(rate_sel));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_count <= 2'h0;
        end else if (next_ramp_state == volume_ramp_pkg::RAMP_IDLE || update_now) begin
            frame_count <= 2'h0;
        end else if (fs_tick) begin
            frame_count <= frame_count + 2'h1;
        end
    end

    // ==========================================================
    // gain stepping, clamped at target
    always_comb begin
        next_volume_code = volume_code;
        if (rate_sel == `RATE_INSTANT) begin
            next_volume_code = target;
        end else if (volume_code < target) begin
            next_volume_code = (target - volume_code <= step_codes(step_sel))
                ? target : volume_code + step_codes(step_sel);
        end else begin
            next_volume_code = (volume_code - target <= step_codes(step_sel))
                ? target : volume_code - step_codes(step_sel);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            volume_code <= `RST_VOLUME_LEVEL;
        end else if (update_now) begin
            volume_code <= next_volume_code;
        end
    end

    gain_apply u_gain (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .volume_code (volume_code),
        .in_sample   (in_sample),
        .in_valid    (in_valid),
        .out_sample  (out_sample),
        .out_valid   (out_valid)
    );

    // ==========================================================
    // assertions
    property p_bclk_rate;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> clock_health_flags[`BIT_BCLK_RATE_ERR] == $past(health.bclk_rate_bad);
    endproperty
    a_bclk_rate: assert property (p_bclk_rate) else $error("rate flag wrong");

    property p_pll_disabled;
        @(posedge ref_clk) disable iff (rst)
        !health.pll_enabled |=> !clock_health_flags[`BIT_PLL_LOCKED];
    endproperty
    a_pll_disabled: assert property (p_pll_disabled) else $error("lock shown while off");

    property p_bclk_valid;
        @(posedge ref_clk) disable iff (rst)
        (health.bclk_ratio > `BCLK_RATIO_MAX || health.bclk_ratio < `BCLK_RATIO_MIN
         || !health.ratio_stable) |=> !clock_health_flags[`BIT_BCLK_VALID];
    endproperty
    a_bclk_valid: assert property (p_bclk_valid) else $error("bad ratio shown valid");

    property p_fs_ignore;
        @(posedge ref_clk) disable iff (rst)
        (!health.fs_auto_mode && health.fs_error_ignore
         && health.detected_fs != health.configured_fs) |=> clock_health_flags[`BIT_FS_ERROR];
    endproperty
    a_fs_ignore: assert property (p_fs_ignore) else $error("rate error masked");

    property p_mute_out;
        @(posedge ref_clk) disable iff (rst)
        (in_valid && volume_code == `VOLUME_MUTE) |=> out_sample == '0;
    endproperty
    a_mute_out: assert property (p_mute_out) else $error("mute not silent");

    property p_instant_fall;
        @(posedge ref_clk) disable iff (rst)
        (fs_tick && next_ramp_state == volume_ramp_pkg::RAMP_FALL
         && rate_sel == `RATE_INSTANT) |=> volume_code == $past(target);
    endproperty
    a_instant_fall: assert property (p_instant_fall) else $error("no instant fall");

    property p_fall_step;
        @(posedge ref_clk) disable iff (rst)
        (update_now && volume_code < target && rate_sel != `RATE_INSTANT)
        |=> volume_code - $past(volume_code) <= $past(step_codes(step_sel));
    endproperty
    a_fall_step: assert property (p_fall_step) else $error("fall step too big");

    property p_rise_step;
        @(posedge ref_clk) disable iff (rst)
        (update_now && volume_code > target && rate_sel != `RATE_INSTANT)
        |=> $past(volume_code) - volume_code == $past(step_codes(step_sel))
            || volume_code == $past(target);
    endproperty
    a_rise_step: assert property (p_rise_step) else $error("rise step wrong");

    property p_emerg_mute;
        @(posedge ref_clk) disable iff (rst)
        (health.emergency_mute && fs_tick && rate_sel == `RATE_INSTANT
         && next_ramp_state == volume_ramp_pkg::RAMP_EMERG) |=> volume_code == `VOLUME_MUTE;
    endproperty
    a_emerg_mute: assert property (p_emerg_mute) else $error("no emergency mute");

    property p_no_overshoot;
        @(posedge ref_clk) disable iff (rst)
        (volume_code < target) |=> volume_code <= $past(target);
    endproperty
    a_no_overshoot: assert property (p_no_overshoot) else $error("ramp overshoot");

    property p_frame_only;
        @(posedge ref_clk) disable iff (rst)
        !fs_tick |=> $stable(volume_code);
    endproperty
    a_frame_only: assert property (p_frame_only) else $error("gain moved mid-frame");

    c_fall: cover property (@(posedge ref_clk) ramp_state == volume_ramp_pkg::RAMP_FALL);
    c_rise: cover property (@(posedge ref_clk) ramp_state == volume_ramp_pkg::RAMP_RISE);
    c_emerg: cover property (@(posedge ref_clk) ramp_state == volume_ramp_pkg::RAMP_EMERG);
    c_reach: cover property (@(posedge ref_clk)
        ramp_state != volume_ramp_pkg::RAMP_IDLE ##1 ramp_state == volume_ramp_pkg::RAMP_IDLE);

endmodule

// ### testbench/audio_source.sv
// Purpose: upstream frame source, one frame strobe and one stereo sample per frame
// Assumes: ref_clk domain; sample follows the strobe by GAP cycles
// Notes:   sample lines change every cycle outside in_valid
`timescale 1ns/100ps

module audio_source #(
    parameter int          FRAME = 16,
    parameter int          GAP   = 2,
    parameter logic [23:0] LEVEL = 24'h040000
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    output logic                            fs_tick,
    output logic                            in_valid,
    output volume_ramp_pkg::stereo_sample_t in_sample
);
    int cnt;

    // ==========================================================
    // frame pacing, driven off the sampling edge
    always @(negedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            fs_tick <= 1'b0;
            in_valid <= 1'b0;
            in_sample <= '0;
        end else begin
            cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
            fs_tick <= (cnt == 0);
            in_valid <= (cnt == GAP);
            in_sample <= (cnt == GAP) ? {LEVEL, 24'h000000 - LEVEL} : ~in_sample;
        end
    end
endmodule

// ### testbench/tb.sv
// Purpose: register, status and ramp checks of volume_ramp
// Assumes: frames from audio_source every 16 cycles
// Notes:   expected gains use codes that are exact powers of two
`timescale 1ns/100ps

module tb;
    localparam logic [23:0] S = 24'h040000;
    localparam logic [7:0]  RA [5] = '{8'h4C, 8'h4E, 8'h4F, 8'h39, 8'h4D};
    localparam logic [7:0]  RV [5] = '{8'h30, 8'h33, 8'h30, 8'h00, 8'h00};
    localparam logic [27:0] HV [15] = '{28'h8000000, 28'h4000000, 28'h2000000,
        28'h3000000, 28'h0800000, 28'h0420000, 28'h041F000, 28'h0600000, 28'h0601000,
        28'h0020000, 28'h0000C00, 28'h0000800, 28'h0000154, 28'h0000158, 28'h000015A};
    localparam logic [5:0]  HX [15] = '{6'h20, 6'h10, 6'h00, 6'h08, 6'h04, 6'h02,
        6'h00, 6'h02, 6'h00, 6'h00, 6'h01, 6'h00, 6'h00, 6'h01, 6'h01};
    logic                            ref_clk, rst, reg_wr, reg_rd, fs_tick, in_valid, out_valid;
    logic [7:0]                      reg_addr, reg_wdata, reg_rdata, rd;
    volume_ramp_pkg::health_in_t     health_in;
    volume_ramp_pkg::stereo_sample_t in_sample, out_sample;
    int                              n_fail = 0;
    int                              n_tests = 0;

    volume_ramp volume_ramp_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .health_in(health_in), .fs_tick(fs_tick), .in_sample(in_sample),
        .in_valid(in_valid), .out_sample(out_sample), .out_valid(out_valid));
    audio_source #(.FRAME(16), .GAP(2), .LEVEL(S)) audio_source_i (.ref_clk(ref_clk),
        .rst(rst), .fs_tick(fs_tick), .in_valid(in_valid), .in_sample(in_sample));

    // ==========================================================
    // helpers
    function automatic logic [47:0] stereo(input logic [23:0] v);
        return {v, 24'h000000 - v};
    endfunction

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        rd = reg_rdata;
    endtask

    task automatic frames(input int n);
        repeat (n) @(posedge out_valid);
        @(negedge ref_clk);
    endtask

    // ramp from one code to another, early check and on-time check
    task automatic ramp(input logic [7:0] ctl, input logic [7:0] from, input logic [7:0] to,
                        input logic [47:0] exp, input int u, input int p);
        wr(8'h4E, 8'hCC);
        wr(8'h4C, from);
        frames(2);
        wr(8'h4E, ctl);
        wr(8'h4C, to);
        frames((u - 1) * p);
        check(48'(out_sample == exp), 48'h000000000000);
        frames(p);
        check(out_sample, exp);
    endtask

    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================
    // clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        n_fail++;
        tally_and_finish();
    end

    // ==========================================================
    // main sequence
    initial begin
        int u;
        int p;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        health_in = '0;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd_reg(RA[i]);
            check(48'(rd), 48'(RV[i]));
        end
        wr(8'h4D, 8'hA5);
        rd_reg(8'h4D);
        check(48'(rd), 48'h000000000000);
        wr(8'h39, 8'hFF);
        rd_reg(8'h39);
        check(48'(rd), 48'h0000000000C0);
        wr(8'h39, 8'h00);
        for (int i = 0; i < 15; i++) begin
            @(negedge ref_clk);
            health_in = HV[i];
            repeat (4) @(negedge ref_clk);
            rd_reg(8'h39);
            check(48'(rd), 48'({2'h0, HX[i]}));
        end
        health_in = '0;
        for (int k = 0; k < 16; k++) begin
            p = (k[3:2] == 2'h3) ? 1 : 1 << k[3:2];
            u = (k[3:2] == 2'h3) ? 1 : (11 + (8 >> k[1:0])) / (8 >> k[1:0]);
            ramp({k[3:0], 4'hC}, 8'h30, 8'h3C, stereo(S >> 1), u, p);
            ramp({4'hC, k[3:0]}, 8'h3C, 8'h30, stereo(S), u, p);
        end
        wr(8'h4C, 8'h00);
        frames(2);
        check(out_sample, stereo(S << 4));
        check(48'(out_valid), 48'h000000000001);
        wr(8'h4C, 8'h18);
        frames(2);
        check(out_sample, stereo(S << 2));
        wr(8'h4C, 8'hFF);
        frames(2);
        check(out_sample, 48'h000000000000);
        wr(8'h4E, 8'h3C);
        wr(8'h4C, 8'h30);
        frames(2);
        wr(8'h4C, 8'h48);
        frames(5);
        wr(8'h4C, 8'h3C);
        frames(12);
        check(out_sample, stereo(S >> 1));
        wr(8'h4E, 8'hCC);
        wr(8'h4F, 8'h00);
        frames(1);
        health_in = 28'h0000001;
        frames(24);
        check(48'(out_sample == 48'h000000000000), 48'h000000000000);
        frames(1);
        check(out_sample, 48'h000000000000);
        health_in = '0;
        wr(8'h4F, 8'h0F);
        rd_reg(8'h4F);
        check(48'(rd), 48'h00000000000F);
        tally_and_finish();
    end
endmodule
